/* File: rtl/charger_cfg_pkg.sv */
package charger_cfg_pkg;
	localparam logic [7:0] ADDR_CURRENT = 8'h03;
	localparam logic [7:0] ADDR_VOLTAGE = 8'h04;
	localparam logic [7:0] ADDR_TIMER   = 8'h05;
	localparam logic [7:0] ADDR_PROTECT = 8'h06;

	localparam logic [7:0] RST_CURRENT = 8'h22;
	localparam logic [7:0] RST_VOLTAGE = 8'h58;
	localparam logic [7:0] RST_TIMER   = 8'h9f;
	localparam logic [7:0] RST_PROTECT = 8'h66;

	localparam logic [3:0] CUR_CODE_MAX   = 4'hc;
	localparam logic [4:0] VOLT_CODE_MAX  = 5'h18;
	localparam logic [4:0] VOLT_CODE_SPEC = 5'h0f;

	localparam logic [15:0] CUR_BASE_MA   = 16'h003c;
	localparam logic [15:0] CUR_STEP_MA   = 16'h003c;
	localparam logic [15:0] VOLT_BASE_MV  = 16'h0f10;
	localparam logic [15:0] VOLT_STEP_MV  = 16'h0020;
	localparam logic [15:0] VOLT_SPEC_MV  = 16'h1100;
	localparam logic [15:0] FLOOR_BASE_MV = 16'h0f3c;
	localparam logic [15:0] FLOOR_STEP_MV = 16'h0064;
	localparam logic [15:0] OVP_MV_0      = 16'h157c;
	localparam logic [15:0] OVP_MV_1      = 16'h1964;
	localparam logic [15:0] OVP_MV_2      = 16'h2904;
	localparam logic [15:0] OVP_MV_3      = 16'h36b0;
	localparam logic [7:0]  TOPOFF_MIN_STEP = 8'h0f;
	localparam logic [7:0]  WDOG_S_BASE     = 8'h28;
	localparam logic [3:0]  FAST_HRS_SHORT  = 4'h5;
	localparam logic [3:0]  FAST_HRS_LONG   = 4'ha;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] precharge_ma;
		logic [15:0] term_ma;
		logic [15:0] charge_mv;
		logic [7:0]  topoff_min;
		logic        topoff_on;
		logic        recharge_200mv;
		logic        term_allow;
		logic        fet_off;
		logic [7:0]  watchdog_s;
		logic        safety_timer_on;
		logic [3:0]  fast_charge_hrs;
		logic        treg_110c;
		logic        cold_iset_20pct;
		logic [15:0] ovp_mv;
		logic [1:0]  boost_code;
		logic [15:0] floor_mv;
	} cfg_out_t;
endpackage

/* File: rtl/charger_config_registers.sv */
// Function
// - Precharge code is 60 mA plus 60 mA per step, resets to 0010, clamps above 1100.
// - Termination code is 60 mA plus 60 mA per step, resets to 0010, clamps above 1100.
// - Charge voltage code is 3.856 V plus 32 mV per step and resets to 01011.
// - Charge voltage codes above 11000 clamp to 11000 and 01111 means 4.352 V.
// - Top-off field selects off, 15, 30 or 45 minutes.
// - With top-off off, charging ends right at termination with no extension.
// - Termination enable allows termination when 1 and resets to 1.
// - The protection FET disable only acts while high-impedance mode is on.
// - Watchdog field selects off, 40 s, 80 s or 160 s and resets to 01.
// - Safety timer enable gates fast charge and precharge timers together, reset on.
// - Fast charge limit is 5 h when 0 and 10 h when 1, reset 1.
// - Overvoltage field selects 5.5, 6.5, 10.5 or 14 V and resets to 01.
// - Input floor code is 3.9 V plus 100 mV per step up to 5.4 V, reset 0110.
`timescale 1ns/10ps
module charger_config_registers (
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	input  wire charger_cfg_pkg::reg_req_t req,
	input  wire logic                      reg_reset,
	input  wire logic                      watchdog_expired,
	input  wire logic                      high_impedance_mode,
	input  wire logic                      precharge_active,
	input  wire logic                      fast_charge_active,
	input  wire logic                      term_conditions_met,
	input  wire logic                      topoff_expired,
	output logic [7:0]                     rdata,
	output charger_cfg_pkg::cfg_out_t      cfg,
	output logic                           precharge_timer_run,
	output logic                           fast_charge_timer_run,
	output logic                           charge_done
);
	import charger_cfg_pkg::*;

	logic [7:0] current_reg;
	logic [7:0] voltage_reg;
	logic [7:0] timer_reg;
	logic [7:0] protect_reg;

	function automatic logic [3:0] clamp_cur(input logic [3:0] code);
		clamp_cur = (code > CUR_CODE_MAX) ? CUR_CODE_MAX : code;
	endfunction

	function automatic logic [15:0] cur_ma(input logic [3:0] code);
		cur_ma = CUR_BASE_MA + CUR_STEP_MA * {12'h000, code};
	endfunction

	wire wr_current = req.wr && (req.addr == ADDR_CURRENT);
	wire wr_voltage = req.wr && (req.addr == ADDR_VOLTAGE);
	wire wr_timer   = req.wr && (req.addr == ADDR_TIMER);
	wire wr_protect = req.wr && (req.addr == ADDR_PROTECT);
	wire soft_reset = reg_reset || watchdog_expired;

	wire [4:0] wr_volt_code = req.wdata[7:3];
	wire [4:0] clamped_volt = (wr_volt_code > VOLT_CODE_MAX) ? VOLT_CODE_MAX
	                                                         : wr_volt_code;
	wire [7:0] next_current = {clamp_cur(req.wdata[7:4]), clamp_cur(req.wdata[3:0])};
	wire [7:0] next_voltage = {clamped_volt, req.wdata[2:0]};

	// Watchdog expiry restores the charge registers only
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			current_reg <= RST_CURRENT;
			voltage_reg <= RST_VOLTAGE;
			timer_reg   <= RST_TIMER;
		end else if (soft_reset) begin
			current_reg <= RST_CURRENT;
			voltage_reg <= RST_VOLTAGE;
			timer_reg   <= RST_TIMER;
		end else begin
			if (wr_current)
				current_reg <= next_current;
			if (wr_voltage)
				voltage_reg <= next_voltage;
			if (wr_timer)
				timer_reg <= req.wdata;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			protect_reg <= RST_PROTECT;
		end else if (reg_reset) begin
			protect_reg <= RST_PROTECT;
		end else if (wr_protect) begin
			protect_reg <= req.wdata;
		end
	end

	wire [7:0] next_rdata = (req.addr == ADDR_CURRENT) ? current_reg :
	                        (req.addr == ADDR_VOLTAGE) ? voltage_reg :
	                        (req.addr == ADDR_TIMER)   ? timer_reg   :
	                        (req.addr == ADDR_PROTECT) ? protect_reg : 8'h00;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	// Decoded settings
	wire [4:0] volt_code  = voltage_reg[7:3];
	wire [1:0] topoff     = voltage_reg[2:1];
	wire [1:0] wdog       = timer_reg[5:4];
	wire [1:0] input_overvoltage_level        = protect_reg[7:6];
	wire [3:0] floor_code = protect_reg[3:0];

	wire [15:0] volt_linear = VOLT_BASE_MV + VOLT_STEP_MV * {11'h000, volt_code};
	wire [15:0] volt_mv     = (volt_code == VOLT_CODE_SPEC) ? VOLT_SPEC_MV
	                                                        : volt_linear;
	wire [7:0]  topoff_min  = TOPOFF_MIN_STEP * {6'h00, topoff};
	wire [7:0]  wdog_s      = (wdog == 2'b00) ? 8'h00
	                                          : (WDOG_S_BASE << (wdog - 2'b01));
	wire [15:0] ovp_mv      = (input_overvoltage_level == 2'b00) ? OVP_MV_0 :
	                          (input_overvoltage_level == 2'b01) ? OVP_MV_1 :
	                          (input_overvoltage_level == 2'b10) ? OVP_MV_2 : OVP_MV_3;
	wire [15:0] floor_mv    = FLOOR_BASE_MV + FLOOR_STEP_MV * {12'h000, floor_code};
	wire        term_allow  = timer_reg[7];
	wire        timers_on   = timer_reg[3];
	wire        topoff_on   = (topoff != 2'b00);

	always_comb begin
		cfg.precharge_ma     = cur_ma(current_reg[7:4]);
		cfg.term_ma          = cur_ma(current_reg[3:0]);
		cfg.charge_mv        = volt_mv;
		cfg.topoff_min       = topoff_min;
		cfg.topoff_on        = topoff_on;
		cfg.recharge_200mv   = voltage_reg[0];
		cfg.term_allow       = term_allow;
		cfg.fet_off          = timer_reg[6] && high_impedance_mode;
		cfg.watchdog_s       = wdog_s;
		cfg.safety_timer_on  = timers_on;
		cfg.fast_charge_hrs  = timer_reg[2] ? FAST_HRS_LONG : FAST_HRS_SHORT;
		cfg.treg_110c        = timer_reg[1];
		cfg.cold_iset_20pct  = timer_reg[0];
		cfg.ovp_mv           = ovp_mv;
		cfg.boost_code       = protect_reg[5:4];
		cfg.floor_mv         = floor_mv;
	end

	assign precharge_timer_run   = timers_on && precharge_active;
	assign fast_charge_timer_run = timers_on && fast_charge_active;
	// Termination ends charge at once, or after the top-off period
	assign charge_done = term_allow && term_conditions_met
	                     && (!topoff_on || topoff_expired);
endmodule

/* File: verification/cfg_host_model.sv */
`timescale 1ns/10ps
module cfg_host (
	input  wire logic                 mclk,
	output charger_cfg_pkg::reg_req_t req,
	input  wire logic [7:0]           rdata
);
	import charger_cfg_pkg::*;
	initial req = '0;
	// Whole-byte write, strobe held for one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		req <= '{addr: a, wdata: v, wr: 1'b1};
		@(posedge mclk);
		req.wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		req.addr <= a;
		repeat (2) @(posedge mclk);
		v = rdata;
	endtask
endmodule

/* File: verification/charger_cfg_properties.sv */
`timescale 1ns/10ps
module charger_cfg_properties (
	input wire logic                      mclk,
	input wire logic                      resetn,
	input wire charger_cfg_pkg::reg_req_t req,
	input wire logic                      reg_reset,
	input wire logic                      watchdog_expired,
	input wire logic                      high_impedance_mode,
	input wire logic [7:0]                rdata,
	input wire charger_cfg_pkg::cfg_out_t cfg,
	input wire logic                      precharge_timer_run,
	input wire logic                      fast_charge_timer_run
);
	import charger_cfg_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	fet_gate_a: assert property (cfg.fet_off |-> high_impedance_mode) else $error("fet off");
	cur_clamp_a: assert property (cfg.precharge_ma <= 16'h030c && cfg.term_ma <= 16'h030c)
		else $error("current over clamp");
	volt_clamp_a: assert property (cfg.charge_mv <= 16'h1210) else $error("voltage");
	floor_range_a: assert property (cfg.floor_mv inside {[16'h0f3c:16'h1518]}) else $error("floor");
	timer_gate_a: assert property (!cfg.safety_timer_on |-> !precharge_timer_run
		&& !fast_charge_timer_run) else $error("timer runs while off");
	reg_restore_a: assert property (reg_reset |=> cfg.floor_mv == 16'h1194
		&& cfg.precharge_ma == 16'h00b4 && cfg.charge_mv == 16'h1070) else $error("reg reset");
	wdog_restore_a: assert property (watchdog_expired |=> cfg.watchdog_s == 8'h28
		&& cfg.term_allow && cfg.fast_charge_hrs == 4'ha) else $error("watchdog restore");
	wdog_keep_a: assert property ((watchdog_expired && !reg_reset && !req.wr)
		|=> $stable(cfg.ovp_mv)) else $error("protection lost");
	unmapped_read_a: assert property ((req.addr < 8'h03 || req.addr > 8'h06) |=> rdata == 8'h00)
		else $error("unmapped read");
	readback_a: assert property ((req.wr && req.addr == 8'h05 && !reg_reset && !watchdog_expired)
		##1 (req.addr == 8'h05 && !reg_reset && !watchdog_expired)
		|=> rdata == $past(req.wdata, 2)) else $error("readback");
endmodule
bind charger_config_registers charger_cfg_properties chk_u (.mclk(mclk), .resetn(resetn),
	.req(req), .reg_reset(reg_reset), .watchdog_expired(watchdog_expired), .rdata(rdata),
	.high_impedance_mode(high_impedance_mode), .cfg(cfg), .precharge_timer_run(precharge_timer_run),
	.fast_charge_timer_run(fast_charge_timer_run));

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import charger_cfg_pkg::*;
	logic       mclk, resetn, reg_reset, wdog, hiz, pre, term, pre_run, done;
	logic       fast, topx, fast_run;
	logic [7:0] rdata, d;
	reg_req_t   req;
	cfg_out_t   cfg;
	int         err_count, check_count, cyc;
	initial begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end
	charger_config_registers dut_u (.mclk(mclk), .resetn(resetn), .req(req), .reg_reset(reg_reset),
		.watchdog_expired(wdog), .high_impedance_mode(hiz), .precharge_active(pre),
		.fast_charge_active(fast), .term_conditions_met(term), .topoff_expired(topx),
		.rdata(rdata), .cfg(cfg), .precharge_timer_run(pre_run), .fast_charge_timer_run(fast_run),
		.charge_done(done));
	cfg_host host_u (.mclk(mclk), .req(req), .rdata(rdata));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask
	task tick;
		@(posedge mclk);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task t_clamp;
		host_u.wr(8'h03, 8'hff);
		rchk(8'h03, 8'hcc);
		chk(cfg.precharge_ma, 16'h030c);
		host_u.wr(8'h04, 8'hfe);
		rchk(8'h04, 8'hc6);
		chk(cfg.topoff_min, 16'h002d);
		host_u.wr(8'h04, 8'h7a);
		chk(cfg.charge_mv, 16'h1100);
		chk(cfg.topoff_min, 16'h000f);
		host_u.wr(8'h04, 8'h04);
		chk(cfg.charge_mv, 16'h0f10);
		chk(cfg.topoff_min, 16'h001e);
	endtask
	task t_protect;
		host_u.wr(8'h06, 8'hff);
		chk(cfg.ovp_mv, 16'h36b0);
		chk(cfg.floor_mv, 16'h1518);
		host_u.wr(8'h05, 8'h40);
		chk(cfg.fet_off, 0);
		chk(cfg.watchdog_s, 16'h0000);
		chk(cfg.safety_timer_on, 0);
		hiz <= 1;
		pre <= 1;
		fast <= 1;
		tick;
		chk(cfg.fet_off, 1);
		chk(fast_run, 0);
		chk({pre_run, cfg.fast_charge_hrs}, 16'h0005);
		wdog <= 1;
		tick;
		wdog <= 0;
		tick;
		rchk(8'h05, 8'h9f);
		chk(pre_run, 1);
		chk(fast_run, 1);
		rchk(8'h06, 8'hff);
		reg_reset <= 1;
		tick;
		reg_reset <= 0;
		tick;
		rchk(8'h06, 8'h66);
		rchk(8'h07, 8'h00);
	endtask
	task t_done;
		term <= 1;
		tick;
		chk({cfg.topoff_on, done}, 16'h0001);
		host_u.wr(8'h04, 8'h5a);
		chk(done, 0);
		topx <= 1;
		tick;
		chk(done, 1);
		host_u.wr(8'h05, 8'h3f);
		chk(done, 0);
		chk(cfg.watchdog_s, 16'h00a0);
	endtask
	initial begin
		{resetn, reg_reset, wdog, hiz, pre, term, fast, topx} = '0;
		repeat (6) tick;
		resetn <= 1;
		tick;
		rchk(8'h03, 8'h22);
		rchk(8'h04, 8'h58);
		chk(cfg.charge_mv, 16'h1070);
		chk(cfg.term_ma, 16'h00b4);
		chk(cfg.floor_mv, 16'h1194);
		chk(cfg.watchdog_s, 16'h0028);
		t_clamp;
		t_protect;
		t_done;
		complete_run;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			complete_run;
		end
	end
endmodule
